// File: rtl/acc_edge.sv
// Per-comparator inversion and edge event detector
`timescale 1ns/1ps
module acc_edge
    import acc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic raw_i,
    input wire logic run_i,
    input wire logic invert_i,
    input wire logic [1:0] edge_sel_i,
    output logic result_o,
    output logic event_o
);
    logic res_q, res_d, ev_q, ev_d;
    logic rise, fall;
    always_comb begin
        res_d = run_i ? (raw_i ^ invert_i) : 1'b0;
        rise = run_i && res_d && !res_q;
        fall = run_i && !res_d && res_q;
        case (acc_edge_type'(edge_sel_i))
            ACC_EDGE_RISE: ev_d = rise;
            ACC_EDGE_FALL: ev_d = fall;
            ACC_EDGE_BOTH: ev_d = rise | fall;
            default: ev_d = 1'b0;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_q <= 1'b0;
            ev_q <= 1'b0;
        end else begin
            res_q <= res_d;
            ev_q <= ev_d;
        end
    end
    assign result_o = res_q;
    assign event_o = ev_q;
endmodule

// File: rtl/acc_params.svh
// Register offsets, field positions, reset values and the overview of operation
// Overview of operation
// - Bit 15 of a comparator control register switches that comparator on or off without touching other bits.
// - Bit 14 drives the comparator result onto its own output pin when set while the comparator runs, and leaves the pin undriven otherwise.
// - Bit 13 inverts the comparator result when set and passes it unchanged when clear.
// - The inversion also applies ahead of edge detection, so the interrupt comes on the opposite edge to the one selected.
// - Read-only bit 8 of each control register shows the live result level and resets to 0.
// - The edge select field at bits 7:6 raises an event on a rising edge for 01, a falling edge for 10, either edge for 11, and never for 00.
// - Bit 4 routes the positive input to the adjustable reference when set and to pin A when clear.
// - Bits 1:0 route the negative input to pin B, C or D for 00, 01 or 10, and to the fixed reference for 11.
// - Status bit 13 stops all comparators while the system is idle when set, and lets them run when clear.
// - Status bits 0, 1 and 2 mirror the live results of comparators 1, 2 and 3.
// - Unassigned bits read as zero and ignore writes.
// - Each control register and the status register has clear, set and invert aliases at 0x4, 0x8 and 0xC above its base.
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH
`define ACC_CTRL0_OFS 8'h00
`define ACC_CTRL1_OFS 8'h10
`define ACC_CTRL2_OFS 8'h20
`define ACC_STAT_OFS 8'h60
`define ACC_IRQ_STAT_OFS 8'h70
`define ACC_IRQ_CLR_OFS 8'h74
`define ACC_IRQ_EN_OFS 8'h78
`define ACC_ALIAS_CLR 2'h1
`define ACC_ALIAS_SET 2'h2
`define ACC_ALIAS_INV 2'h3
`define ACC_BIT_ON 15
`define ACC_BIT_OE 14
`define ACC_BIT_INV 13
`define ACC_BIT_LIVE 8
`define ACC_BIT_EVH 7
`define ACC_BIT_EVL 6
`define ACC_BIT_PSEL 4
`define ACC_BIT_NSH 1
`define ACC_BIT_NSL 0
`define ACC_BIT_STOP_IN_IDLE 13
`define ACC_CTRL_WMASK 32'h0000E0D3
`define ACC_STAT_WMASK 32'h00002000
`define ACC_CTRL_RESET 32'h000000C3
`define ACC_STAT_RESET 32'h00000000
`endif

// File: rtl/acc_pkg.sv
// Types shared by the comparator control block
package acc_pkg;
    typedef enum logic [1:0] {
        ACC_EDGE_NONE = 2'h0,
        ACC_EDGE_RISE = 2'h1,
        ACC_EDGE_FALL = 2'h2,
        ACC_EDGE_BOTH = 2'h3
    } acc_edge_type;
    typedef enum logic [2:0] {
        ACC_BUS_IDLE = 3'h1,
        ACC_BUS_ACK = 3'h2,
        ACC_BUS_GAP = 3'h4
    } acc_bus_type;
endpackage

// File: rtl/acc_sync.sv
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module acc_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic level_o
);
    logic s1_q, s2_q, s3_q, lvl_q;
    logic s1_d, s2_d, s3_d, lvl_d;
    always_comb begin
        s1_d = pin_i;
        s2_d = s1_q;
        s3_d = s2_q;
        lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            lvl_q <= 1'b0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            lvl_q <= lvl_d;
        end
    end
    assign level_o = lvl_q;
endmodule

// File: rtl/acc_top.sv
// Comparator control and status register bank with Wishbone slave
`timescale 1ns/1ps
`include "acc_params.svh"
module acc_top
    import acc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic idle_i,
    input wire logic [2:0] comparator_raw_i,
    output logic [2:0] comparator_power_o,
    output logic [2:0] positive_input_select_o,
    output logic [5:0] negative_input_select_o,
    output logic [2:0] result_output_pin_o,
    output logic [2:0] result_output_pin_oe_o,
    output logic [2:0] event_pulse_o,
    output logic irq_o
);
    logic [31:0] ctrl_q [3];
    logic [31:0] ctrl_d [3];
    logic stop_in_idle_q, stop_in_idle_d;
    logic [2:0] ists_q, ists_d, ien_q, ien_d;
    logic [31:0] rdat_q, rdat_d;
    logic ack_q, ack_d;
    logic irq_q, irq_d;
    logic [2:0] pwr_q, pwr_d, psel_q, psel_d, pin_q, pin_d, oe_q, oe_d, evo_q;
    logic [5:0] nsel_q, nsel_d;
    logic [2:0] raw_s, live, ev, run;
    logic idle_s;
    logic [31:0] wmask;
    logic [31:0] stat_new;
    logic req, wr;
    logic [1:0] alias_sel;
    logic [7:0] base;

    acc_sync u_idle_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(idle_i),
        .level_o(idle_s)
    );

    for (genvar i = 0; i < 3; i++) begin : g_cmp
        acc_sync u_sync (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .pin_i(comparator_raw_i[i]),
            .level_o(raw_s[i])
        );
        // Stop in idle forces every comparator off
        assign run[i] = ctrl_q[i][`ACC_BIT_ON] && !(stop_in_idle_q && idle_s);
        acc_edge u_edge (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .raw_i(raw_s[i]),
            .run_i(run[i]),
            .invert_i(ctrl_q[i][`ACC_BIT_INV]),
            .edge_sel_i(ctrl_q[i][`ACC_BIT_EVH:`ACC_BIT_EVL]),
            .result_o(live[i]),
            .event_o(ev[i])
        );
    end

    // Sub-word strobes only update enabled byte lanes
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
        end
        req = wb_cyc_i && wb_stb_i && !ack_q;
        wr = req && wb_we_i;
        alias_sel = wb_adr_i[3:2];
        base = {wb_adr_i[7:4], 4'h0};
    end

    function automatic logic [31:0] apply(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [31:0] msk, input logic [1:0] op);
        logic [31:0] m;
        m = dat & msk;
        case (op)
            `ACC_ALIAS_CLR: apply = old & ~m;
            `ACC_ALIAS_SET: apply = old | m;
            `ACC_ALIAS_INV: apply = old ^ m;
            default: apply = (old & ~msk) | m;
        endcase
    endfunction

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            ctrl_d[i] = ctrl_q[i];
            if (wr && base == 8'(i * 16)) begin
                ctrl_d[i] = apply(ctrl_q[i], wb_dat_i, wmask & `ACC_CTRL_WMASK, alias_sel);
            end
            ctrl_d[i][`ACC_BIT_LIVE] = live[i];
        end
        stop_in_idle_d = stop_in_idle_q;
        stat_new = apply({18'h0, stop_in_idle_q, 13'h0}, wb_dat_i, wmask & `ACC_STAT_WMASK,
                         alias_sel);
        if (wr && base == `ACC_STAT_OFS) begin
            stop_in_idle_d = stat_new[`ACC_BIT_STOP_IN_IDLE];
        end
        ien_d = ien_q;
        if (wr && wb_adr_i == `ACC_IRQ_EN_OFS && wb_sel_i[0]) begin
            ien_d = wb_dat_i[2:0];
        end
        // New events win over a simultaneous clear
        ists_d = ists_q;
        if (wr && wb_adr_i == `ACC_IRQ_CLR_OFS && wb_sel_i[0]) begin
            ists_d = ists_q & ~wb_dat_i[2:0];
        end
        ists_d = ists_d | ev;
        irq_d = |(ists_d & ien_d);
        rdat_d = 32'h00000000;
        if (req && !wb_we_i) begin
            case (base)
                `ACC_CTRL0_OFS: rdat_d = ctrl_q[0];
                `ACC_CTRL1_OFS: rdat_d = ctrl_q[1];
                `ACC_CTRL2_OFS: rdat_d = ctrl_q[2];
                `ACC_STAT_OFS: rdat_d = {18'h0, stop_in_idle_q, 10'h0, live};
                8'h70: begin
                    if (wb_adr_i == `ACC_IRQ_STAT_OFS) begin
                        rdat_d = {29'h0, ists_q};
                    end else if (wb_adr_i == `ACC_IRQ_EN_OFS) begin
                        rdat_d = {29'h0, ien_q};
                    end
                end
                default: rdat_d = 32'h00000000;
            endcase
        end
        ack_d = req;
        for (int i = 0; i < 3; i++) begin
            pwr_d[i] = run[i];
            psel_d[i] = ctrl_q[i][`ACC_BIT_PSEL];
            nsel_d[i*2 +: 2] = ctrl_q[i][`ACC_BIT_NSH:`ACC_BIT_NSL];
            oe_d[i] = ctrl_q[i][`ACC_BIT_OE] && run[i];
            pin_d[i] = oe_d[i] && live[i];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 3; i++) begin
                ctrl_q[i] <= `ACC_CTRL_RESET;
            end
            stop_in_idle_q <= 1'b0;
            ists_q <= 3'h0;
            ien_q <= 3'h0;
            rdat_q <= 32'h00000000;
            ack_q <= 1'b0;
            irq_q <= 1'b0;
            pwr_q <= 3'h0;
            psel_q <= 3'h0;
            nsel_q <= 6'h3F;
            pin_q <= 3'h0;
            oe_q <= 3'h0;
            evo_q <= 3'h0;
        end else begin
            ctrl_q <= ctrl_d;
            stop_in_idle_q <= stop_in_idle_d;
            ists_q <= ists_d;
            ien_q <= ien_d;
            rdat_q <= rdat_d;
            ack_q <= ack_d;
            irq_q <= irq_d;
            pwr_q <= pwr_d;
            psel_q <= psel_d;
            nsel_q <= nsel_d;
            pin_q <= pin_d;
            oe_q <= oe_d;
            evo_q <= ev;
        end
    end

    assign wb_dat_o = rdat_q;
    assign wb_ack_o = ack_q;
    assign irq_o = irq_q;
    assign comparator_power_o = pwr_q;
    assign positive_input_select_o = psel_q;
    assign negative_input_select_o = nsel_q;
    assign result_output_pin_o = pin_q;
    assign result_output_pin_oe_o = oe_q;
    assign event_pulse_o = evo_q;

    property p_ack_one;
        @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");
    property p_ack_req;
        @(posedge clk_i) disable iff (rst_i) (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
    endproperty
    a_ack_req: assert property (p_ack_req) else $error("request not acked");
    property p_live_bit;
        @(posedge clk_i) disable iff (rst_i) ##1 ctrl_q[0][`ACC_BIT_LIVE] == $past(live[0]);
    endproperty
    a_live_bit: assert property (p_live_bit) else $error("live bit stale");
    property p_unused_zero;
        @(posedge clk_i) disable iff (rst_i) (ctrl_q[1] & ~32'h0000E1D3) == 32'h0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("reserved bit set");
    property p_off_no_event;
        @(posedge clk_i) disable iff (rst_i) !run[0] ##1 !run[0] |=> !event_pulse_o[0];
    endproperty
    a_off_no_event: assert property (p_off_no_event) else $error("event while off");
    property p_pulse_one;
        @(posedge clk_i) disable iff (rst_i)
            (event_pulse_o[2] && ctrl_q[2][7:6] != 2'h3) |=> !event_pulse_o[2];
    endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("event pulse too long");
    property p_idle_stop;
        @(posedge clk_i) disable iff (rst_i) (stop_in_idle_q && idle_s) |=> comparator_power_o == 3'h0;
    endproperty
    a_idle_stop: assert property (p_idle_stop) else $error("comparator runs in idle");
    property p_oe_off;
        @(posedge clk_i) disable iff (rst_i) !ctrl_q[1][`ACC_BIT_OE] |=> !result_output_pin_oe_o[1];
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("pin driven while disabled");
    property p_irq;
        @(posedge clk_i) disable iff (rst_i) irq_o == $past(|(ists_d & ien_d));
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");
    c_write: cover property (@(posedge clk_i) disable iff (rst_i) wr ##1 wb_ack_o);
    c_event: cover property (@(posedge clk_i) disable iff (rst_i) |event_pulse_o);
    c_irq: cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
    c_idle: cover property (@(posedge clk_i) disable iff (rst_i) stop_in_idle_q && idle_s);
    c_alias: cover property (@(posedge clk_i) disable iff (rst_i) wr && alias_sel != 2'h0);

    // Input routing outputs track the stored selects one cycle later
    property p_psel_follow;
        @(posedge clk_i) disable iff (rst_i)
            ##1 positive_input_select_o == $past({ctrl_q[2][4], ctrl_q[1][4], ctrl_q[0][4]});
    endproperty
    a_psel_follow: assert property (p_psel_follow) else $error("positive select stale");

    property p_nsel_follow;
        @(posedge clk_i) disable iff (rst_i)
            ##1 negative_input_select_o == $past({ctrl_q[2][1:0], ctrl_q[1][1:0], ctrl_q[0][1:0]});
    endproperty
    a_nsel_follow: assert property (p_nsel_follow) else $error("negative select stale");

    // Power, pin drive and register hold
    property p_power_off;
        @(posedge clk_i) disable iff (rst_i) !ctrl_q[2][`ACC_BIT_ON] |=> !comparator_power_o[2];
    endproperty
    a_power_off: assert property (p_power_off) else $error("disabled core powered");

    property p_power_on;
        @(posedge clk_i) disable iff (rst_i)
            (!stop_in_idle_q && ctrl_q[1][`ACC_BIT_ON]) |=> comparator_power_o[1];
    endproperty
    a_power_on: assert property (p_power_on) else $error("enabled core unpowered");

    property p_pin_needs_oe;
        @(posedge clk_i) disable iff (rst_i) result_output_pin_o[0] |-> result_output_pin_oe_o[0];
    endproperty
    a_pin_needs_oe: assert property (p_pin_needs_oe) else $error("pin high while undriven");

    property p_oe_follow;
        @(posedge clk_i) disable iff (rst_i)
            (ctrl_q[2][`ACC_BIT_OE] && run[2]) |=> result_output_pin_oe_o[2];
    endproperty
    a_oe_follow: assert property (p_oe_follow) else $error("pin not driven");

    property p_ctrl_hold;
        @(posedge clk_i) disable iff (rst_i)
            !(wr && base == `ACC_CTRL0_OFS) |=> ctrl_q[0][15:9] == $past(ctrl_q[0][15:9]);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed unwritten");

    property p_stop_in_idle_hold;
        @(posedge clk_i) disable iff (rst_i) !(wr && base == `ACC_STAT_OFS) |=> $stable(stop_in_idle_q);
    endproperty
    a_stop_in_idle_hold: assert property (p_stop_in_idle_hold) else $error("stop in idle changed");

    // Read data
    property p_stat_read;
        @(posedge clk_i) disable iff (rst_i)
            (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == `ACC_STAT_OFS)
            |=> wb_dat_o[2:0] == $past(live);
    endproperty
    a_stat_read: assert property (p_stat_read) else $error("status mirror wrong");

    property p_read_high_zero;
        @(posedge clk_i) disable iff (rst_i) wb_ack_o |-> wb_dat_o[31:16] == 16'h0000;
    endproperty
    a_read_high_zero: assert property (p_read_high_zero) else $error("upper half set");

    property p_data_idle;
        @(posedge clk_i) disable iff (rst_i) !wb_ack_o |-> wb_dat_o == 32'h00000000;
    endproperty
    a_data_idle: assert property (p_data_idle) else $error("read data outside ack");

    // Events and interrupt
    property p_no_sel_no_event;
        @(posedge clk_i) disable iff (rst_i)
            ctrl_q[0][7:6] == 2'h0 ##1 ctrl_q[0][7:6] == 2'h0 |=> !event_pulse_o[0];
    endproperty
    a_no_sel_no_event: assert property (p_no_sel_no_event) else $error("event unselected");

    property p_sticky;
        @(posedge clk_i) disable iff (rst_i)
            (ists_q[1] && !(wr && wb_adr_i == `ACC_IRQ_CLR_OFS && wb_sel_i[0])) |=> ists_q[1];
    endproperty
    a_sticky: assert property (p_sticky) else $error("status bit lost");

    property p_irq_masked;
        @(posedge clk_i) disable iff (rst_i) (ien_q == 3'h0 && !wr) |=> !irq_o;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked irq raised");
endmodule

// File: sim/acc_cmp_model.sv
// Behavioural model of the three comparator cores and their input pins
`timescale 1ns/1ps
module acc_cmp_model (
    input wire logic clk_i,
    input wire logic [2:0] power_i,
    input wire logic [2:0] psel_i,
    input wire logic [5:0] nsel_i,
    input wire logic [2:0] pin_a_i,
    input wire logic [3:0] neg_lvl_i,
    input wire logic adj_ref_i,
    output logic [2:0] raw_o
);
    logic tog_q = 1'b0;
    logic pos;
    always_ff @(posedge clk_i) begin
        tog_q <= ~tog_q;
    end
    // Negative levels are {fixed ref, pin D, pin C, pin B}
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pos = psel_i[i] ? adj_ref_i : pin_a_i[i];
            // An unpowered core has no valid result, so it wanders
            raw_o[i] = power_i[i] ? (pos & ~neg_lvl_i[nsel_i[2*i+:2]]) : tog_q;
        end
    end
endmodule

// File: sim/tb.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
module tb;
    import acc_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, idle_i = 1'b0;
    logic adj = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat;
    logic [2:0] raw, pwr, psel, pin, oe, evp, pin_a = 3'h0;
    logic [3:0] neg = 4'h0;
    logic [5:0] nsel;
    logic ack, irq;
    int err_count = 0, checks = 0;
    always #4 clk_i = ~clk_i;
    acc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .idle_i(idle_i), .comparator_raw_i(raw), .comparator_power_o(pwr),
        .positive_input_select_o(psel), .negative_input_select_o(nsel),
        .result_output_pin_o(pin), .result_output_pin_oe_o(oe), .event_pulse_o(evp),
        .irq_o(irq));
    acc_cmp_model CORES (.clk_i(clk_i), .power_i(pwr), .psel_i(psel), .nsel_i(nsel),
        .pin_a_i(pin_a), .neg_lvl_i(neg), .adj_ref_i(adj), .raw_o(raw));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("checks=%0d mismatches=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 50) err_count++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task cnt(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge clk_i);
            if (evp[0] === 1'b1) c++;
        end
    endtask
    task t_reset;
        rd(8'h00, 32'h000000C3);
        rd(8'h10, 32'h000000C3);
        rd(8'h20, 32'h000000C3);
        rd(8'h60, 32'h00000000);
        chk({nsel, oe, pwr}, {6'h3F, 3'h0, 3'h0});
        $display("test reset done");
    endtask
    task t_regs;
        wr(8'h00, 32'hFFFF7FFF);
        rd(8'h00, 32'h000060D3);
        wr(8'h04, 32'h00000040);
        rd(8'h00, 32'h00006093);
        wr(8'h08, 32'h00000040);
        rd(8'h00, 32'h000060D3);
        wr(8'h0C, 32'h00002003);
        rd(8'h00, 32'h000040D0);
        chk({psel[0], nsel[1:0]}, 3'h4);
        wr(8'h60, 32'hFFFFFFFF);
        rd(8'h60, 32'h00002000);
        wr(8'h64, 32'h00002000);
        rd(8'h60, 32'h00000000);
        rd(8'h40, 32'h00000000);
        $display("test registers done");
    endtask
    task t_route;
        pin_a <= 3'h1;
        for (int n = 0; n < 4; n++) begin
            wr(8'h00, 32'h00008000 | n);
            chk(nsel[1:0], n[1:0]);
            neg <= 4'h1 << n;
            repeat (8) @(posedge clk_i);
            rd(8'h60, 32'h00000000);
            neg <= ~(4'h1 << n);
            repeat (8) @(posedge clk_i);
            rd(8'h60, 32'h00000001);
        end
        wr(8'h00, 32'h00008010);
        pin_a <= 3'h0;
        adj <= 1'b1;
        neg <= 4'h0;
        repeat (8) @(posedge clk_i);
        rd(8'h00, 32'h00008110);
        wr(8'h10, 32'h00008010);
        wr(8'h20, 32'h00008010);
        repeat (8) @(posedge clk_i);
        rd(8'h60, 32'h00000007);
        $display("test routing done");
    endtask
    task t_edge;
        int c;
        logic [1:0] m;
        logic iv;
        wr(8'h78, 32'h00000001);
        for (int k = 0; k < 8; k++) begin
            m = k[1:0];
            iv = k[2];
            pin_a <= 3'h0;
            wr(8'h00, {16'h0, 1'b1, 1'b0, iv, 5'h0, m, 6'h0});
            cnt(12, c);
            pin_a <= 3'h1;
            cnt(12, c);
            chk(c, iv ? m[1] : m[0]);
            pin_a <= 3'h0;
            cnt(12, c);
            chk(c, iv ? m[0] : m[1]);
        end
        chk(irq, 1'b1);
        rd(8'h70, 32'h00000001);
        wr(8'h74, 32'h00000001);
        repeat (2) @(posedge clk_i);
        chk(irq, 1'b0);
        wr(8'h78, 32'h00000000);
        pin_a <= 3'h1;
        cnt(12, c);
        chk({c[0], irq}, 2'h2);
        rd(8'h70, 32'h00000001);
        $display("test events done");
    endtask
    task t_pin_idle;
        wr(8'h00, 32'h0000C000);
        repeat (8) @(posedge clk_i);
        chk({oe[0], pin[0]}, 2'h3);
        wr(8'h60, 32'h00002000);
        idle_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk(pwr[0], 1'b0);
        rd(8'h00, 32'h0000C000);
        idle_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk(pwr[0], 1'b1);
        wr(8'h04, 32'h00004000);
        repeat (8) @(posedge clk_i);
        chk(oe[0], 1'b0);
        // The bus task leaves an idle cycle after turning a core off
        wr(8'h04, 32'h00008000);
        repeat (2) @(posedge clk_i);
        chk(pwr[0], 1'b0);
        $display("test pin and idle done");
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset;
        t_regs;
        t_route;
        t_edge;
        t_pin_idle;
        close_out;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        close_out;
    end
endmodule
